//--- ocpwm_pkg.sv
// Package for the four-channel output compare and PWM block.
// Assumes a 16-bit counter and a plain strobe register port with 16-bit data.
package ocpwm_pkg;
	localparam int CNT_W = 16;
	localparam int NUM_CH = 4;
	// Register offsets, word index on the plain port.
	localparam logic [3:0] OFF_STATUS = 4'h0;
	localparam logic [3:0] OFF_MODULO = 4'h1;
	localparam logic [3:0] OFF_COUNT = 4'h2;
	localparam logic [3:0] OFF_CTRL0 = 4'h4;
	localparam logic [3:0] OFF_VAL0 = 4'h8;
	// Timer status register fields.
	localparam int ST_WRAP_FLAG = 7;
	localparam int ST_WRAP_IE = 6;
	localparam int ST_STOP = 5;
	localparam int ST_RESET = 4;
	localparam int ST_ACTIVE0 = 0;
	localparam int ST_ACTIVE2 = 1;
	// Channel control fields.
	localparam int CC_FLAG = 7;
	localparam int CC_IE = 6;
	localparam int CC_MSH = 5;
	localparam int CC_MSL = 4;
	localparam int CC_ELH = 3;
	localparam int CC_ELL = 2;
	localparam int CC_TOV = 1;
	localparam int CC_MAX = 0;
	localparam logic [15:0] MODULO_RST = 16'hFFFF;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] STATUS_RST = 16'h0020;
	typedef enum logic [1:0] {
		OCPWM_ACT_NONE = 2'b00,
		OCPWM_ACT_TOGGLE = 2'b01,
		OCPWM_ACT_CLEAR = 2'b10,
		OCPWM_ACT_SET = 2'b11
	} ocpwm_action_t;
endpackage

//--- ocpwm_pin.sv
// One channel pin driver: applies overflow toggle and compare action.
// Assumes single-cycle event pulses from the timer top on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ocpwm_pin (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic enable_i,
	input wire logic wrap_i,
	input wire logic match_i,
	input wire ocpwm_pkg::ocpwm_action_t action_i,
	input wire logic tov_i,
	input wire logic max_i,
	output logic pin_o
);
	import ocpwm_pkg::*;
	logic pin_reg;
	logic pin_next;
	logic cmp_level;
	logic cmp_hit;
	// A compare that lands on the wrap cycle beats the wrap, so a value of zero
	// gives a zero-width pulse rather than a stray toggle. Full duty masks compares.
	assign cmp_hit = match_i && !max_i && (action_i != OCPWM_ACT_NONE);
	assign cmp_level = (action_i == OCPWM_ACT_SET) ? 1'b1 :
		(action_i == OCPWM_ACT_CLEAR) ? 1'b0 : !pin_reg;
	always_comb begin
		pin_next = pin_reg;
		if (!enable_i) begin
			pin_next = 1'b0;
		end else if (cmp_hit) begin
			pin_next = cmp_level;
		end else if (wrap_i && tov_i) begin
			pin_next = max_i ? (action_i == OCPWM_ACT_CLEAR) : !pin_reg;
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_reg <= 1'b0;
		end else begin
			pin_reg <= pin_next;
		end
	end
	assign pin_o = pin_reg;
endmodule
`default_nettype wire

//--- ocpwm_timer.sv
// Four-channel output compare and PWM timer with its counter and registers.
// Assumes a same-clock register master: one-cycle strobes, read data next cycle.
// Operation
// - Unbuffered compare value sits in one register; a write replaces it at once.
// - Compare fires only on counter equal to stored value; passed values miss.
// - Unsynchronised writes may upset output up to two overflow periods.
// - Smaller value written in overflow service may be passed already and missed.
// - Channel interrupt request raised at compare match, ending the pulse.
// - Overflow interrupt request raised when counter completes modulo period.
// - Raising the value above count in same period gives a second match.
// - Pair 0/1 link bit joins channels 0 and 1; output on channel 0 pin.
// - Even channel rules first; last-written set takes over at each overflow.
// - Linked pair: even control governs, odd control ignored, odd pin released.
// - Pair 2/3 link bit joins channels 2 and 3; channel 3 pin released.
// - Writing the active channel of a pair acts immediately, as unbuffered.
// - Toggle-on-overflow toggles pin when counter reaches modulo value.
// - Pulse width is time from overflow to channel compare match.
// - Modulo 255 undivided gives period of 256 clocks; count 0..modulo.
// - Value 128 with modulo 255 gives 50 percent duty.
// - Wrap flag sets on reaching modulo; request raised if enabled.
// - Toggle-on-overflow clear suppresses toggles; output holds zero duty.
// - Full-duty bit with toggle-on-overflow forces 100 percent duty.
// - Mode 0:1 unbuffered, 1:x buffered; edge 1:0 clears, 1:1 sets.
`timescale 1ns/1ps
`default_nettype none
module ocpwm_timer #(
	parameter int PRESCALE_W = 3
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	output logic [3:0] channel_pin_o,
	output logic [3:0] channel_pin_oe_o,
	output logic wrap_irq_o,
	output logic [3:0] channel_irq_o
);
	import ocpwm_pkg::*;
	logic [15:0] status_reg;
	logic [15:0] modulo_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_nxt;
	logic [PRESCALE_W-1:0] div_reg;
	logic [7:0] ctrl_reg [NUM_CH];
	logic [CNT_W-1:0] value_reg [NUM_CH];
	logic [1:0] active_reg;
	logic [1:0] pending_reg;
	logic [15:0] rdata_reg;
	logic [3:0] oe_reg;
	logic wrap_irq_reg;
	logic [3:0] ch_irq_reg;
	logic tick;
	logic wrap;
	logic [3:0] match;
	logic [3:0] pin_raw;
	logic [1:0] link;
	logic wr_status;
	logic wr_modulo;
	logic [3:0] wr_ctrl;
	logic [3:0] wr_val;
	logic [2:0] ps_sel;
	logic [15:0] rd_mux;

	// Prescaler: divide by two to the power of the three-bit select, at most two to the power of PRESCALE_W.
	assign ps_sel = status_reg[2:0];
	assign tick = !status_reg[ST_STOP] &&
		((div_reg & PRESCALE_W'((1 << ps_sel) - 1)) == '0);
	assign wrap = tick && (count_reg == modulo_reg);
	// Compares look at the count about to be shown, so the pin moves exactly
	// as the counter reaches the value; otherwise every pulse is one count longer.
	assign count_nxt = wrap ? '0 : count_reg + CNT_W'(1);

	// Register address decode.
	assign wr_status = reg_wr_i && (reg_addr_i == OFF_STATUS);
	assign wr_modulo = reg_wr_i && (reg_addr_i == OFF_MODULO);
	assign link[0] = ctrl_reg[0][CC_MSH];
	assign link[1] = ctrl_reg[2][CC_MSH];

	always_comb begin
		if (reg_addr_i == OFF_STATUS) begin
			rd_mux = {status_reg[15:2], active_reg};
		end else if (reg_addr_i == OFF_MODULO) begin
			rd_mux = modulo_reg;
		end else if (reg_addr_i == OFF_COUNT) begin
			rd_mux = count_reg;
		end else if (reg_addr_i[3:2] == OFF_CTRL0[3:2]) begin
			rd_mux = {8'h00, ctrl_reg[reg_addr_i[1:0]]};
		end else if (reg_addr_i[3:2] == OFF_VAL0[3:2]) begin
			rd_mux = value_reg[reg_addr_i[1:0]];
		end else begin
			rd_mux = 16'h0000;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_reg <= '0;
			count_reg <= '0;
		end else if (wr_status && reg_wdata_i[ST_RESET]) begin
			div_reg <= '0;
			count_reg <= '0;
		end else if (!status_reg[ST_STOP]) begin
			div_reg <= div_reg + PRESCALE_W'(1);
			if (wrap) begin
				count_reg <= '0;
			end else if (tick) begin
				count_reg <= count_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_reg <= STATUS_RST;
			modulo_reg <= MODULO_RST;
		end else begin
			if (wr_modulo) begin
				modulo_reg <= reg_wdata_i;
			end
			if (wr_status) begin
				status_reg[ST_WRAP_IE] <= reg_wdata_i[ST_WRAP_IE];
				status_reg[ST_STOP] <= reg_wdata_i[ST_STOP];
				status_reg[2:0] <= reg_wdata_i[2:0];
			end
			// Set beats a software clear (write zero) in the same cycle.
			if (wrap) begin
				status_reg[ST_WRAP_FLAG] <= 1'b1;
			end else if (wr_status && !reg_wdata_i[ST_WRAP_FLAG]) begin
				status_reg[ST_WRAP_FLAG] <= 1'b0;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			localparam int EVEN = g & 2;
			localparam int PAIR = g / 2;
			logic odd_slave;
			logic governs;
			logic flag_set;
			logic [7:0] ctl;
			assign wr_ctrl[g] = reg_wr_i && (reg_addr_i == OFF_CTRL0 + 4'(g));
			assign wr_val[g] = reg_wr_i && (reg_addr_i == OFF_VAL0 + 4'(g));
			assign odd_slave = (g % 2 == 1) && link[PAIR];
			// Only the active channel of a linked pair compares against the count.
			assign governs = (g % 2 == 0) ? (!link[PAIR] || !active_reg[PAIR]) :
				(!link[PAIR] || active_reg[PAIR]);
			assign match[g] = tick && governs && (count_nxt == value_reg[g]);
			assign flag_set = (g % 2 == 0) ? (match[g] || (link[PAIR] && match[g | 1])) :
				(match[g] && !link[PAIR]);
			assign ctl = ctrl_reg[EVEN];

			always_ff @(posedge core_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					ctrl_reg[g] <= CTRL_RST;
					value_reg[g] <= '0;
				end else begin
					if (wr_val[g]) begin
						value_reg[g] <= reg_wdata_i;
					end
					if (wr_ctrl[g]) begin
						ctrl_reg[g][6:0] <= reg_wdata_i[6:0];
					end
					// Flag of a linked pair is reported on the even control.
					if (flag_set) begin
						ctrl_reg[g][CC_FLAG] <= 1'b1;
					end else if (wr_ctrl[g] && !reg_wdata_i[CC_FLAG]) begin
						ctrl_reg[g][CC_FLAG] <= 1'b0;
					end
				end
			end

			if (g % 2 == 0) begin : g_pin
				logic mode_on;
				logic pair_match;
				assign pair_match = match[g] || (link[PAIR] && match[g+1]);
				assign mode_on = ctl[CC_MSH] || ctl[CC_MSL];
				ocpwm_pin u_pin (
					.core_clk_i(core_clk_i),
					.arst_n_i(arst_n_i),
					.enable_i(mode_on),
					.wrap_i(wrap),
					.match_i(pair_match),
					.action_i(ocpwm_action_t'(ctl[CC_ELH:CC_ELL])),
					.tov_i(ctl[CC_TOV]),
					.max_i(ctl[CC_MAX]),
					.pin_o(pin_raw[g])
				);
			end else begin : g_pin
				ocpwm_pin u_pin (
					.core_clk_i(core_clk_i),
					.arst_n_i(arst_n_i),
					.enable_i(!odd_slave && ctrl_reg[g][CC_MSL]),
					.wrap_i(wrap),
					.match_i(match[g]),
					.action_i(ocpwm_action_t'(ctrl_reg[g][CC_ELH:CC_ELL])),
					.tov_i(ctrl_reg[g][CC_TOV]),
					.max_i(ctrl_reg[g][CC_MAX]),
					.pin_o(pin_raw[g])
				);
			end
		end
	endgenerate

	// Buffered pairs: remember the last-written channel, swap at overflow.
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			active_reg <= 2'b00;
			pending_reg <= 2'b00;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (!link[p]) begin
					active_reg[p] <= 1'b0;
					pending_reg[p] <= 1'b0;
				end else begin
					if (wr_val[2*p+1]) begin
						pending_reg[p] <= 1'b1;
					end else if (wr_val[2*p]) begin
						pending_reg[p] <= 1'b0;
					end
					if (wrap) begin
						active_reg[p] <= pending_reg[p];
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 16'h0000;
			oe_reg <= 4'h0;
			wrap_irq_reg <= 1'b0;
			ch_irq_reg <= 4'h0;
		end else begin
			if (reg_rd_i) begin
				rdata_reg <= rd_mux;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				oe_reg[c] <= (ctrl_reg[c][CC_MSH] || ctrl_reg[c][CC_MSL]) &&
					!(c % 2 == 1 && link[c/2]);
				ch_irq_reg[c] <= ctrl_reg[c][CC_FLAG] && ctrl_reg[c][CC_IE];
			end
			wrap_irq_reg <= status_reg[ST_WRAP_FLAG] && status_reg[ST_WRAP_IE];
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign channel_pin_o = pin_raw;
	assign channel_pin_oe_o = oe_reg;
	assign wrap_irq_o = wrap_irq_reg;
	assign channel_irq_o = ch_irq_reg;
endmodule
`default_nettype wire

//--- ocpwm_timer_props.sv
// Port checker for the output compare and PWM timer.
// Assumes one clock domain and the plain strobe register port.
`timescale 1ns/1ps
`default_nettype none
module ocpwm_timer_props import ocpwm_pkg::*; #(
	parameter int PRESCALE_W = 3
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [3:0] channel_pin_o,
	input wire logic [3:0] channel_pin_oe_o,
	input wire logic wrap_irq_o,
	input wire logic [3:0] channel_irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence wr_bit(logic [3:0] a, int b, logic v);
		reg_wr_i && reg_addr_i == a && reg_wdata_i[b] == v;
	endsequence
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 4'h3 |=> reg_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_wrap_irq_off: assert property (wr_bit(OFF_STATUS, ST_WRAP_IE, 1'b0) |-> ##3 !wrap_irq_o)
		else $error("wrap request stays with enable clear");
	a_chan_irq_off: assert property (wr_bit(OFF_CTRL0, CC_IE, 1'b0) |-> ##3 !channel_irq_o[0])
		else $error("channel request stays with enable clear");
	a_link01_release: assert property (wr_bit(OFF_CTRL0, CC_MSH, 1'b1) |-> ##3 !channel_pin_oe_o[1])
		else $error("odd pin still driven in linked pair");
	a_link23_release: assert property (wr_bit(4'h6, CC_MSH, 1'b1) |-> ##3 !channel_pin_oe_o[3])
		else $error("pin 3 still driven in linked pair");
	a_mode_enable: assert property (reg_wr_i && reg_addr_i == OFF_CTRL0 && reg_wdata_i[5:4] == 2'b01
		|-> ##3 channel_pin_oe_o[0])
		else $error("enabled channel not driving its pin");
	a_idle_pin_low: assert property (!channel_pin_oe_o[0] && !$past(channel_pin_oe_o[0])
		|-> !channel_pin_o[0])
		else $error("undriven pin not low");
endmodule
bind ocpwm_timer ocpwm_timer_props #(.PRESCALE_W(PRESCALE_W)) props_u (
	.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .channel_pin_o(channel_pin_o),
	.channel_pin_oe_o(channel_pin_oe_o), .wrap_irq_o(wrap_irq_o), .channel_irq_o(channel_irq_o));
`default_nettype wire

//--- ocpwm_load.sv
// Load on one channel pin: measures PWM period and high time.
// Assumes a pull-up on the pin while the channel releases it.
`timescale 1ns/1ps
`default_nettype none
module ocpwm_load (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic pin_i,
	input wire logic oe_i,
	output logic level_o,
	output logic [15:0] period_o,
	output logic [15:0] high_o
);
	logic last_reg;
	logic [15:0] per_reg;
	logic [15:0] hi_reg;
	// A released pin is pulled up, so it never keeps a stale low.
	assign level_o = oe_i ? pin_i : 1'b1;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_reg <= 1'b0;
			per_reg <= 16'h0000;
			hi_reg <= 16'h0000;
			period_o <= 16'h0000;
			high_o <= 16'h0000;
		end else if (level_o && !last_reg) begin
			last_reg <= 1'b1;
			period_o <= per_reg;
			high_o <= hi_reg;
			per_reg <= 16'h0001;
			hi_reg <= 16'h0001;
		end else begin
			last_reg <= level_o;
			per_reg <= per_reg + 16'h0001;
			hi_reg <= hi_reg + {15'h0000, level_o};
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the output compare and PWM timer.
// Assumes the timer, its checker and the pin load model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ocpwm_pkg::*;
	typedef struct {logic [3:0] a; logic w; logic [15:0] d; logic [15:0] e;} ocpwm_row_t;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic [3:0] channel_pin_o;
	logic [3:0] channel_pin_oe_o;
	logic wrap_irq_o;
	logic [3:0] channel_irq_o;
	logic level0;
	logic [15:0] period0;
	logic [15:0] high0;
	int n_fail = 0;
	int check_count = 0;
	int hi;
	ocpwm_row_t rows [8] = '{'{OFF_STATUS, 1'b0, 16'h0000, STATUS_RST},
		'{OFF_MODULO, 1'b0, 16'h0000, MODULO_RST}, '{OFF_CTRL0, 1'b0, 16'h0000, {8'h00, CTRL_RST}},
		'{4'h3, 1'b1, 16'h1234, 16'h0000}, '{OFF_COUNT, 1'b1, 16'h1234, 16'h0000},
		'{OFF_MODULO, 1'b1, 16'h00FF, 16'h00FF}, '{4'h5, 1'b1, 16'h0016, 16'h0016},
		'{OFF_VAL0, 1'b1, 16'h0080, 16'h0080}};
	always #12.5 core_clk_i = ~core_clk_i;
	ocpwm_timer #(.PRESCALE_W(3)) dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .channel_pin_o(channel_pin_o),
		.channel_pin_oe_o(channel_pin_oe_o), .wrap_irq_o(wrap_irq_o), .channel_irq_o(channel_irq_o));
	ocpwm_load load_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .pin_i(channel_pin_o[0]),
		.oe_i(channel_pin_oe_o[0]), .level_o(level0), .period_o(period0), .high_o(high0));
	task automatic tally_and_finish();
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Each access leaves one idle edge so a strobe is never lowered and raised at once.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("register", reg_rdata_o, e);
		@(posedge core_clk_i);
	endtask
	task automatic dwell(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge core_clk_i);
			hi += int'(level0);
		end
	endtask
	task automatic wait_irq(input logic [4:0] mask);
		int k;
		k = 0;
		while (({wrap_irq_o, channel_irq_o} & mask) == 5'h00 && k < 600) begin
			@(posedge core_clk_i);
			k++;
		end
		chk("interrupt", {15'h0000, k < 600}, 16'h0001);
		if (k >= 600)
			tally_and_finish();
	endtask
	initial begin
		repeat (2) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		wr(OFF_CTRL0, 16'h001A);
		wr(OFF_STATUS, 16'h0010);
		repeat (600) @(posedge core_clk_i);
		chk("period", period0, 16'h0100);
		chk("high time", high0, 16'h0080);
		wr(OFF_CTRL0, 16'h0018);
		dwell(300);
		dwell(300);
		chk("zero duty", hi[15:0], 16'h0000);
		wr(OFF_CTRL0, 16'h001B);
		dwell(300);
		dwell(300);
		chk("full duty", hi[15:0], 16'h012C);
		wr(OFF_CTRL0, 16'h005A);
		wait_irq(5'h01);
		wr(OFF_VAL0, 16'h0060);
		wr(OFF_CTRL0, 16'h001A);
		wr(OFF_STATUS, 16'h0040);
		wait_irq(5'h10);
		wr(OFF_VAL0, 16'h0080);
		wr(OFF_STATUS, 16'h0000);
		wr(OFF_CTRL0, 16'h002A);
		// Enables are registered after the control write, so look once they settle.
		@(negedge core_clk_i);
		chk("pin enables", {12'h000, channel_pin_oe_o}, 16'h0001);
		@(posedge core_clk_i);
		wr(OFF_VAL0 + 4'h1, 16'h0040);
		repeat (600) @(posedge core_clk_i);
		chk("odd high time", high0, 16'h0040);
		rd(OFF_STATUS, 16'h0081);
		wr(OFF_VAL0, 16'h00C0);
		repeat (600) @(posedge core_clk_i);
		chk("even high time", high0, 16'h00C0);
		wr(OFF_CTRL0 + 4'h2, 16'h002A);
		@(negedge core_clk_i);
		chk("pin enables", {12'h000, channel_pin_oe_o}, 16'h0005);
		@(posedge core_clk_i);
		arst_n_i <= 1'b0;
		@(posedge core_clk_i);
		chk("reset enables", {12'h000, channel_pin_oe_o}, 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
